// >>> enc_model.sv
`default_nettype none
// ****************************************
// Incremental encoder on the pin side
// ****************************************
module enc_model
  import qdec_pkg::*;
(
  // Clock and commands
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic rev_i,
  input wire logic jump_i,
  input wire logic idx_i,
  // Encoder pins
  output enc_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pos_reg = 2'h0;
  // Gray position, phase A leads going forward
  always_ff @(posedge clk_i)
  begin
    if (jump_i)
      pos_reg <= pos_reg + 2'h2;
    else if (step_i)
      pos_reg <= rev_i ? pos_reg - 2'h1 : pos_reg + 2'h1;
  end
  // Pin levels
  assign pins_o.a = pos_reg[1] ^ pos_reg[0];
  assign pins_o.b = pos_reg[1];
  assign pins_o.idx = idx_i;
endmodule
`default_nettype wire

// >>> noise_filter.sv
`include "qdec_params.svh"
`default_nettype none
// ****************************************
// One-input digital noise filter
// ****************************************
module noise_filter
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Sample strobe and data
  input wire logic sample_i,
  input wire logic din_i,
  output logic dout_o
);
  logic [1:0] cnt_reg;
  logic out_reg;
  wire differs = (din_i != out_reg);
  // Accept level only after it holds for several samples
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_reg <= 2'h0;
      out_reg <= 1'b0;
    end
    else if (ce_i && sample_i)
    begin
      if (!differs)
        cnt_reg <= 2'h0;
      else if (cnt_reg == 2'(`FLT_STABLE_SAMPLES - 1))
      begin
        cnt_reg <= 2'h0;
        out_reg <= din_i;
      end
      else
        cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign dout_o = out_reg;
endmodule
`default_nettype wire

// >>> qdec_params.svh
`ifndef QDEC_PARAMS_SVH
`define QDEC_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_ENC_CTRL 8'h00
`define OFS_FLT_CTRL 8'h04
`define OFS_POS_CNT 8'h08
`define OFS_MAX_CNT 8'h0C
`define OFS_AUX_CTRL 8'h10
// ****************************************
// Encoder control field positions
// ****************************************
`define ENC_ERR_BIT 15
`define ENC_IDLE_BIT 13
`define ENC_INDEX_BIT 12
`define ENC_DIR_BIT 11
`define ENC_MODE_HI 10
`define ENC_MODE_LO 8
`define ENC_SWAP_BIT 7
`define ENC_DIROE_BIT 6
`define ENC_GATE_BIT 5
`define ENC_PS_HI 4
`define ENC_PS_LO 3
`define ENC_IDXRST_BIT 2
`define ENC_TCS_BIT 1
`define ENC_DSRC_BIT 0
// ****************************************
// Filter control field positions
// ****************************************
`define FLT_IMV_HI 10
`define FLT_IMV_LO 9
`define FLT_COUNT_ERROR_IRQ_DISABLE_BIT 8
`define FLT_OUT_BIT 7
`define FLT_CK_HI 6
`define FLT_CK_LO 4
// ****************************************
// Reset values and writable masks
// ****************************************
`define ENC_CTRL_RST 16'h0000
`define FLT_CTRL_RST 16'h0000
`define MAX_CNT_RST 16'hFFFF
`define ENC_WR_MASK 16'hA7FF
`define FLT_WR_MASK 16'h07F0
// ****************************************
// Timing counts
// ****************************************
`define FLT_STABLE_SAMPLES 3
`endif

// >>> qdec_pkg.sv
`default_nettype none
package qdec_pkg;
  // Mode select codes
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_TIMER = 3'h1, MODE_UNUSED2 = 3'h2, MODE_UNUSED3 = 3'h3,
    MODE_X2_IDX = 3'h4, MODE_X2_MATCH = 3'h5, MODE_X4_IDX = 3'h6, MODE_X4_MATCH = 3'h7
  } decode_mode_t;
  // Encoder pins as one bundle
  typedef struct packed {
    logic idx;
    logic b;
    logic a;
  } enc_pins_t;
  // Bus slave response state
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RESP
  } bus_state_t;
endpackage
`default_nettype wire

// >>> qdec_properties.sv
`default_nettype none
// ****************************************
// Port checks for the position decoder
// ****************************************
module qdec_properties
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Direction pin
  input wire logic dir_pin_oe_o,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Bus steps
  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_both_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  chk_ce_freezes: assert property (!ce_i |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready while clock enable low");
  chk_reset_quiet: assert property ($fell(srst_i) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response after reset");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rresp[0])
    else $error("bad read word");
  chk_bresp_code: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("bad write response code");
  chk_oe_by_write: assert property ($changed(dir_pin_oe_o) |-> ##[0:1] s_axi_bvalid)
    else $error("direction enable moved without a write");
endmodule
bind quadrature_position_decoder qdec_properties chk_u (.clk_i, .srst_i, .ce_i, .dir_pin_oe_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

// >>> quadrature_position_decoder.sv
// What this block does
// - Modes 111/110/101/100 select x4/x2 decoding
// - 001 timer, 010/011 disabled, 000 off
// - 16-bit position count up or down
// - Count error flag only in index modes
// - Error interrupt masked by disable bit
// - Halt in idle when bit set
// - Status bit mirrors index pin level
// - Direction read-only in 1xx, writable in 001
// - Swap phases before decoding when set
// - Drive direction pin when enabled
// - Gate input enables timer accumulation
// - Prescale 1/8/64/256, timer mode only
// - Index resets count in index modes
// - Timer clock: phase A rise or cycles
// - Timer direction from phase B or bit
// - x4 index match on both phases
// - x2 index match on chosen phase
// - Filter enable routes inputs through filters
// - Filter clock divide 1..256 select
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "qdec_params.svh"
`default_nettype none
module quadrature_position_decoder
  import qdec_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic idle_i,
  // Encoder pins
  input wire logic phase_a_input_i,
  input wire logic phase_b_input_i,
  input wire logic index_pulse_input_i,
  input wire logic gate_i,
  // Direction pin
  output logic dir_pin_o,
  output logic dir_pin_oe_o,
  // Count error interrupt
  output logic count_error_irq_o,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] enc_ctrl_reg;
  logic [15:0] flt_ctrl_reg;
  logic [CNT_W-1:0] position_count_reg;
  logic [CNT_W-1:0] max_count_limit_reg;
  logic count_error_flag_reg;
  logic count_direction_bit_reg;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic [31:0] rdata_reg;
  bus_state_t wr_state_reg;
  bus_state_t rd_state_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  // ****************************************
  // Field decode
  // ****************************************
  decode_mode_t decode_mode_select;
  assign decode_mode_select = decode_mode_t'(enc_ctrl_reg[`ENC_MODE_HI:`ENC_MODE_LO]);
  wire halt_when_idle = enc_ctrl_reg[`ENC_IDLE_BIT];
  wire phase_swap = enc_ctrl_reg[`ENC_SWAP_BIT];
  wire direction_pin_output_enable = enc_ctrl_reg[`ENC_DIROE_BIT];
  wire gated_accumulation_enable = enc_ctrl_reg[`ENC_GATE_BIT];
  wire [1:0] timer_prescale = enc_ctrl_reg[`ENC_PS_HI:`ENC_PS_LO];
  wire index_reset_enable = enc_ctrl_reg[`ENC_IDXRST_BIT];
  wire timer_clock_source = enc_ctrl_reg[`ENC_TCS_BIT];
  wire direction_source_select = enc_ctrl_reg[`ENC_DSRC_BIT];
  wire [1:0] index_match_value = flt_ctrl_reg[`FLT_IMV_HI:`FLT_IMV_LO];
  wire count_error_irq_disable = flt_ctrl_reg[`FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
  wire filter_output_enable = flt_ctrl_reg[`FLT_OUT_BIT];
  wire [2:0] filter_clock_divide = flt_ctrl_reg[`FLT_CK_HI:`FLT_CK_LO];
  // Mode groups
  wire mode_quad = decode_mode_select[2];
  wire mode_x4 = mode_quad && decode_mode_select[1];
  wire mode_idx = mode_quad && !decode_mode_select[0];
  wire mode_timer = (decode_mode_select == MODE_TIMER);
  // Halt in idle gates all counting state
  wire run = ce_i && !(halt_when_idle && idle_i);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  enc_pins_t pin_meta_reg;
  enc_pins_t pin_sync_reg;
  logic gate_meta_reg;
  logic gate_sync_reg;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_meta_reg <= '{idx: index_pulse_input_i, b: phase_b_input_i, a: phase_a_input_i};
      pin_sync_reg <= pin_meta_reg;
      gate_meta_reg <= gate_i;
      gate_sync_reg <= gate_meta_reg;
    end
  end
  // ****************************************
  // Filter clock divider and filters
  // ****************************************
  logic [7:0] fdiv_reg;
  logic [7:0] fdiv_top;
  always_comb
  begin
    case (filter_clock_divide)
      3'h0: fdiv_top = 8'h00;
      3'h1: fdiv_top = 8'h01;
      3'h2: fdiv_top = 8'h03;
      3'h3: fdiv_top = 8'h0F;
      3'h4: fdiv_top = 8'h1F;
      3'h5: fdiv_top = 8'h3F;
      3'h6: fdiv_top = 8'h7F;
      default: fdiv_top = 8'hFF;
    endcase
  end
  wire fsample = (fdiv_reg >= fdiv_top);
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      fdiv_reg <= 8'h00;
    else if (ce_i)
      fdiv_reg <= fsample ? 8'h00 : fdiv_reg + 8'h01;
  end
  enc_pins_t filt;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_filt
      noise_filter u_filt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .sample_i(fsample),
        .din_i(pin_sync_reg[gi]),
        .dout_o(filt[gi])
      );
    end
  endgenerate
  // Filtered or direct pins, then optional swap
  enc_pins_t pins;
  assign pins = filter_output_enable ? filt : pin_sync_reg;
  wire pa = phase_swap ? pins.b : pins.a;
  wire pb = phase_swap ? pins.a : pins.b;
  // ****************************************
  // Quadrature decode
  // ****************************************
  logic pa_prev_reg;
  logic pb_prev_reg;
  logic idx_prev_reg;
  wire a_chg = pa ^ pa_prev_reg;
  wire b_chg = pb ^ pb_prev_reg;
  wire both_chg = a_chg && b_chg;
  // A leads B when new A differs from old B
  wire a_step_up = pa ^ pb_prev_reg;
  wire b_step_up = ~(pb ^ pa_prev_reg);
  wire q_count = mode_quad && !both_chg && (mode_x4 ? (a_chg || b_chg) : a_chg);
  wire q_up = a_chg ? a_step_up : b_step_up;
  // Index match qualification
  wire idx_rise = pins.idx && !idx_prev_reg;
  wire x4_match = (pb == index_match_value[1]) && (pa == index_match_value[0]);
  wire x2_match = ((index_match_value[1] ? pb : pa) == index_match_value[0]);
  wire idx_ok = idx_rise && (mode_x4 ? x4_match : x2_match);
  wire idx_reset = mode_idx && index_reset_enable && idx_ok;
  wire err_event = mode_idx && both_chg;
  // ****************************************
  // Timer clocking
  // ****************************************
  logic [7:0] pre_reg;
  logic [7:0] pre_top;
  always_comb
  begin
    case (timer_prescale)
      2'h0: pre_top = 8'h00;
      2'h1: pre_top = 8'h07;
      2'h2: pre_top = 8'h3F;
      default: pre_top = 8'hFF;
    endcase
  end
  wire a_rise = pa && !pa_prev_reg;
  wire src_tick = timer_clock_source ? a_rise : 1'b1;
  wire gate_ok = !gated_accumulation_enable || gate_sync_reg;
  wire t_in = mode_timer && src_tick && gate_ok;
  wire t_count = t_in && (pre_reg >= pre_top);
  wire t_up = direction_source_select ? pb : count_direction_bit_reg;
  // ****************************************
  // Position counter
  // ****************************************
  wire do_count = q_count || t_count;
  wire up = mode_quad ? q_up : t_up;
  wire match_mode = mode_quad && decode_mode_select[0];
  logic [CNT_W-1:0] pos_next;
  always_comb
  begin
    pos_next = position_count_reg;
    if (idx_reset)
      pos_next = '0;
    else if (do_count && up)
      pos_next = (match_mode && position_count_reg == max_count_limit_reg) ? '0
                 : position_count_reg + 1'b1;
    else if (do_count)
      pos_next = (match_mode && position_count_reg == '0) ? max_count_limit_reg
                 : position_count_reg - 1'b1;
  end
  // ****************************************
  // AXI4-Lite decode
  // ****************************************
  wire wr_fire = aw_have_reg && w_have_reg && (wr_state_reg == BUS_IDLE);
  wire [15:0] wdat16 = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                        w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
  wire [15:0] wlane = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire wr_enc = wr_fire && (aw_addr_reg == `OFS_ENC_CTRL);
  wire wr_flt = wr_fire && (aw_addr_reg == `OFS_FLT_CTRL);
  wire wr_pos = wr_fire && (aw_addr_reg == `OFS_POS_CNT);
  wire wr_max = wr_fire && (aw_addr_reg == `OFS_MAX_CNT);
  wire wr_hit = wr_enc || wr_flt || wr_pos || wr_max;
  wire [15:0] enc_wm = wlane & `ENC_WR_MASK;
  wire [15:0] flt_wm = wlane & `FLT_WR_MASK;
  // Readback view of the control word
  wire [15:0] enc_view = {count_error_flag_reg, 1'b0, enc_ctrl_reg[`ENC_IDLE_BIT], pins.idx,
                          count_direction_bit_reg, enc_ctrl_reg[10:0]};
  logic [15:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      `OFS_ENC_CTRL: rd_mux = enc_view;
      `OFS_FLT_CTRL: rd_mux = flt_ctrl_reg;
      `OFS_POS_CNT: rd_mux = 16'(position_count_reg);
      `OFS_MAX_CNT: rd_mux = 16'(max_count_limit_reg);
      default: rd_mux = 16'h0000;
    endcase
  end
  wire rd_hit = (s_axi_araddr == `OFS_ENC_CTRL) || (s_axi_araddr == `OFS_FLT_CTRL)
                || (s_axi_araddr == `OFS_POS_CNT) || (s_axi_araddr == `OFS_MAX_CNT);
  // ****************************************
  // Decode state registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pa_prev_reg <= 1'b0;
      pb_prev_reg <= 1'b0;
      idx_prev_reg <= 1'b0;
      pre_reg <= 8'h00;
    end
    else if (run)
    begin
      pa_prev_reg <= pa;
      pb_prev_reg <= pb;
      idx_prev_reg <= pins.idx;
      if (!mode_timer)
        pre_reg <= 8'h00;
      else if (t_in)
        pre_reg <= (pre_reg >= pre_top) ? 8'h00 : pre_reg + 8'h01;
    end
  end
  // ****************************************
  // Control, count and flag registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      enc_ctrl_reg <= `ENC_CTRL_RST;
      flt_ctrl_reg <= `FLT_CTRL_RST;
      max_count_limit_reg <= CNT_W'(`MAX_CNT_RST);
      position_count_reg <= '0;
      count_error_flag_reg <= 1'b0;
      count_direction_bit_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_enc)
        enc_ctrl_reg <= (enc_ctrl_reg & ~enc_wm) | (wdat16 & enc_wm);
      if (wr_flt)
        flt_ctrl_reg <= (flt_ctrl_reg & ~flt_wm) | (wdat16 & flt_wm);
      if (wr_max)
        max_count_limit_reg <= CNT_W'(wdat16);
      // Software write to the count loses to none
      if (wr_pos)
        position_count_reg <= CNT_W'(wdat16);
      else if (run)
        position_count_reg <= pos_next;
      // Set wins over a clear in the same cycle
      if (run && err_event)
        count_error_flag_reg <= 1'b1;
      else if (wr_enc && wlane[`ENC_ERR_BIT])
        count_error_flag_reg <= wdat16[`ENC_ERR_BIT];
      if (run && mode_quad && do_count)
        count_direction_bit_reg <= q_up;
      else if (wr_enc && wlane[`ENC_DIR_BIT] && mode_timer)
        count_direction_bit_reg <= wdat16[`ENC_DIR_BIT];
    end
  end
  // ****************************************
  // AXI4-Lite channel registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wr_state_reg <= BUS_IDLE;
      bresp_reg <= 2'h0;
      rd_state_reg <= BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        wr_state_reg <= BUS_RESP;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (wr_state_reg == BUS_RESP && s_axi_bready)
        wr_state_reg <= BUS_IDLE;
      if (rd_state_reg == BUS_IDLE && s_axi_arvalid)
      begin
        rd_state_reg <= BUS_RESP;
        rdata_reg <= {16'h0000, rd_mux};
        rresp_reg <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (rd_state_reg == BUS_RESP && s_axi_rready)
        rd_state_reg <= BUS_IDLE;
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = ce_i && !aw_have_reg && (wr_state_reg == BUS_IDLE);
  assign s_axi_wready = ce_i && !w_have_reg && (wr_state_reg == BUS_IDLE);
  assign s_axi_bvalid = (wr_state_reg == BUS_RESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ce_i && (rd_state_reg == BUS_IDLE);
  assign s_axi_rvalid = (rd_state_reg == BUS_RESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign dir_pin_o = count_direction_bit_reg;
  assign dir_pin_oe_o = direction_pin_output_enable;
  assign count_error_irq_o = count_error_flag_reg && !count_error_irq_disable;
endmodule
`default_nettype wire

// >>> tb_top.sv
`include "qdec_params.svh"
`default_nettype none
module tb_top
  import qdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Stimulus, model and device
  // ****************************************
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic idle_i = 1'b0;
  logic gate_i = 1'b0;
  logic ce_r = 1'b1;
  logic step_r = 1'b0, rev_r = 1'b0, jump_r = 1'b0, idx_r = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic dir_pin_o, dir_pin_oe_o, count_error_irq_o;
  logic [31:0] d, p;
  enc_pins_t pins;
  int fail_count = 0;
  int checks = 0;
  int lo_t[4] = '{200, 24, 3, 0};
  int hi_t[4] = '{210, 27, 4, 1};
  int off_t[3] = '{0, 2, 3};
  enc_model enc_u (.clk_i, .step_i(step_r), .rev_i(rev_r), .jump_i(jump_r), .idx_i(idx_r), .pins_o(pins));
  quadrature_position_decoder dut_u (.clk_i, .srst_i, .ce_i(ce_r), .idle_i, .phase_a_input_i(pins.a),
    .phase_b_input_i(pins.b), .index_pulse_input_i(pins.idx), .gate_i, .dir_pin_o, .dir_pin_oe_o,
    .count_error_irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic test_done;
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    int n;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++)
    begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp(32'(n < 50), 1);
    if (n == 50)
      test_done;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++)
    begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50)
      fail_count++;
    if (n == 50)
      test_done;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    cmp(d & m, e);
  endtask
  task automatic move(input int n, input logic rev, input int hold);
    repeat (n)
    begin
      @(posedge clk_i);
      step_r <= 1'b1;
      rev_r <= rev;
      @(posedge clk_i);
      step_r <= 1'b0;
      repeat (hold) @(posedge clk_i);
    end
  endtask
  task automatic jump;
    @(posedge clk_i);
    jump_r <= 1'b1;
    @(posedge clk_i);
    jump_r <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic span(input int lo, input int hi);
    rd(`OFS_POS_CNT);
    p = d;
    repeat (200) @(posedge clk_i);
    rd(`OFS_POS_CNT);
    d = (d - p) & 32'h0000FFFF;
    cmp(32'(d >= lo && d <= hi), 1);
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    rdc(`OFS_ENC_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(`OFS_FLT_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(`OFS_MAX_CNT, 32'hFFFFFFFF, 32'h0000FFFF);
    rd(8'h20);
    cmp(d, 32'h0);
    cmp(32'(r), 32'h2);
    wr(`OFS_MAX_CNT, 16'h0003);
    wr(`OFS_ENC_CTRL, 16'h0740);
    cmp(32'(dir_pin_oe_o), 1);
    move(5, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h1);
    rdc(`OFS_ENC_CTRL, 32'h0800, 32'h0800);
    cmp(32'(dir_pin_o), 1);
    move(2, 1'b1, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h3);
    cmp(32'(dir_pin_o), 0);
    wr(`OFS_MAX_CNT, 16'hFFFF);
    wr(`OFS_POS_CNT, 16'h0005);
    wr(`OFS_ENC_CTRL, 16'h0780);
    move(2, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h3);
    wr(`OFS_POS_CNT, 16'h0000);
    wr(`OFS_ENC_CTRL, 16'h0500);
    move(4, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h2);
    foreach (off_t[i])
    begin
      wr(`OFS_ENC_CTRL, 16'(off_t[i] << 8));
      move(4, 1'b0, 10);
      rdc(`OFS_POS_CNT, 32'hFFFF, 32'h2);
    end
    wr(`OFS_ENC_CTRL, 16'h0700);
    jump;
    rdc(`OFS_ENC_CTRL, 32'h8000, 32'h0);
    wr(`OFS_ENC_CTRL, 16'h0600);
    jump;
    rdc(`OFS_ENC_CTRL, 32'h8000, 32'h8000);
    cmp(32'(count_error_irq_o), 1);
    wr(`OFS_FLT_CTRL, 16'h0100);
    cmp(32'(count_error_irq_o), 0);
    wr(`OFS_FLT_CTRL, 16'h0000);
    cmp(32'(count_error_irq_o), 1);
    wr(`OFS_ENC_CTRL, 16'h0604);
    cmp(32'(count_error_irq_o), 0);
    move(1, 1'b1, 10);
    wr(`OFS_POS_CNT, 16'h0010);
    idx_r <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdc(`OFS_ENC_CTRL, 32'h1000, 32'h1000);
    idx_r <= 1'b0;
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h0);
    rdc(`OFS_ENC_CTRL, 32'h1000, 32'h0);
    wr(`OFS_FLT_CTRL, 16'h0600);
    wr(`OFS_POS_CNT, 16'h0010);
    idx_r <= 1'b1;
    repeat (10) @(posedge clk_i);
    idx_r <= 1'b0;
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h10);
    wr(`OFS_ENC_CTRL, 16'h0404);
    wr(`OFS_FLT_CTRL, 16'h0400);
    idx_r <= 1'b1;
    repeat (10) @(posedge clk_i);
    idx_r <= 1'b0;
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h0);
    wr(`OFS_ENC_CTRL, 16'h0100);
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_ENC_CTRL, 16'h0900 | 16'(i << 3));
      span(lo_t[i], hi_t[i]);
    end
    rdc(`OFS_ENC_CTRL, 32'h0800, 32'h0800);
    wr(`OFS_ENC_CTRL, 16'h2900);
    idle_i <= 1'b1;
    span(0, 0);
    idle_i <= 1'b0;
    span(200, 210);
    wr(`OFS_ENC_CTRL, 16'h0920);
    span(0, 0);
    gate_i <= 1'b1;
    span(200, 210);
    rd(`OFS_POS_CNT);
    p = d;
    ce_r <= 1'b0;
    repeat (200) @(posedge clk_i);
    ce_r <= 1'b1;
    rd(`OFS_POS_CNT);
    cmp(32'(((d - p) & 32'h0000FFFF) < 4), 1);
    wr(`OFS_ENC_CTRL, 16'h0100);
    rdc(`OFS_ENC_CTRL, 32'h0800, 32'h0);
    wr(`OFS_ENC_CTRL, 16'h0902);
    wr(`OFS_POS_CNT, 16'h0000);
    move(4, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h1);
    wr(`OFS_ENC_CTRL, 16'h0103);
    move(4, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h0);
    wr(`OFS_ENC_CTRL, 16'h0700);
    wr(`OFS_FLT_CTRL, 16'h00F0);
    wr(`OFS_POS_CNT, 16'h0000);
    move(1, 1'b0, 10);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h0);
    repeat (1100) @(posedge clk_i);
    rdc(`OFS_POS_CNT, 32'hFFFF, 32'h1);
    test_done;
  end
endmodule
`default_nettype wire
